/* File: hdl/fps_map.vh */
// Constants for the flash command sequencer host: codes, offsets, timings
`ifndef FPS_MAP_VH
`define FPS_MAP_VH
// Unlock cycle addresses and data
`define FPS_UNLOCK_ADDR1 22'h000555
`define FPS_UNLOCK_ADDR2 22'h0002AA
`define FPS_UNLOCK_DATA1 8'hAA
`define FPS_UNLOCK_DATA2 8'h55
// Command codes
`define FPS_CMD_ID_READ 8'h90
`define FPS_CMD_PROGRAM 8'hA0
`define FPS_CMD_BUF_LOAD 8'h25
`define FPS_CMD_BUF_COMMIT 8'h29
`define FPS_CMD_RESET 8'hF0
// Identifier read low addresses
`define FPS_ID_MANUF_ADDR 8'h00
`define FPS_ID_DEV1_ADDR 8'h01
`define FPS_ID_PROT_ADDR 8'h02
`define FPS_ID_DEV2_ADDR 8'h0E
`define FPS_ID_DEV3_ADDR 8'h0F
// Status bit positions in read data
`define FPS_POLL_BIT 7
`define FPS_TOGGLE_BIT 6
`define FPS_TIMEOUT_BIT 5
`define FPS_ABORT_BIT 1
// Write buffer size in bytes and page low address bits
`define FPS_BUF_BYTES 32
`define FPS_PAGE_LSB 4
// Bus cycle timing in nanoseconds
`define FPS_STROBE_NS 60
`define FPS_READ_NS 100
`define FPS_CLK_NS 20
`endif

/* File: hdl/fps_bus_cycle.v */
// One bus write or read cycle on the flash pins, paced by the system clock
`timescale 1ns/100ps
`include "fps_map.vh"
module fps_bus_cycle #(
    parameter AW = 22,
    parameter STROBE_CYC = 3,
    parameter READ_CYC = 5
) (
    // Clock and reset
    input wire clock_i,
    input wire reset_i,
    // Cycle request
    input wire start_i,
    input wire write_i,
    input wire [AW-1:0] addr_i,
    input wire [7:0] wdata_i,
    output reg done_o,
    output reg [7:0] rdata_o,
    // Flash pins
    output reg [AW-1:0] flash_addr_o,
    output reg flash_ce_n_o,
    output reg flash_we_n_o,
    output reg flash_oe_n_o,
    output reg [7:0] flash_dq_o,
    output reg flash_dq_oe_o,
    input wire [7:0] flash_dq_i
);
    // Synchronised read data
    reg [7:0] dq_s1_ff;
    reg [7:0] dq_s2_ff;
    // Phase counter and busy flag
    reg [7:0] cnt_ff;
    reg busy_ff;
    reg wr_ff;

    // Two-stage synchroniser on the data pins
    always @(posedge clock_i) begin
        dq_s1_ff <= flash_dq_i;
        dq_s2_ff <= dq_s1_ff;
    end

    // Strobe sequencer: address set first, strobe low, data captured on rise
    always @(posedge clock_i) begin
        if (reset_i) begin
            busy_ff <= 1'b0;
            wr_ff <= 1'b0;
            cnt_ff <= 8'h00;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            flash_addr_o <= {AW{1'b0}};
            flash_ce_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_dq_o <= 8'h00;
            flash_dq_oe_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (!busy_ff) begin
                if (start_i) begin
                    // Address stable before strobe falls
                    busy_ff <= 1'b1;
                    wr_ff <= write_i;
                    cnt_ff <= 8'h00;
                    flash_addr_o <= addr_i;
                    flash_dq_o <= wdata_i;
                    flash_dq_oe_o <= write_i;
                    flash_ce_n_o <= 1'b0;
                end
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
                if (cnt_ff == 8'h00) begin
                    // Falling strobe edge latches address in device
                    flash_we_n_o <= ~wr_ff;
                    flash_oe_n_o <= wr_ff;
                end else if (wr_ff && cnt_ff == STROBE_CYC[7:0]) begin
                    // Rising strobe edge latches data in device
                    flash_we_n_o <= 1'b1;
                end else if (wr_ff && cnt_ff == STROBE_CYC[7:0] + 8'h01) begin
                    flash_ce_n_o <= 1'b1;
                    flash_dq_oe_o <= 1'b0;
                    busy_ff <= 1'b0;
                    done_o <= 1'b1;
                end else if (!wr_ff && cnt_ff == READ_CYC[7:0] + 8'h02) begin
                    // Sample after synchroniser delay
                    rdata_o <= dq_s2_ff;
                    flash_oe_n_o <= 1'b1;
                    flash_ce_n_o <= 1'b1;
                    busy_ff <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule // fps_bus_cycle

/* File: hdl/fps_sequencer.v */
// Host sequencer that drives identifier reads and programming on a NOR flash
`timescale 1ns/100ps
`include "fps_map.vh"
module fps_sequencer #(
    parameter AW = 22,
    parameter BUF_BYTES = `FPS_BUF_BYTES
) (
    // Clock and reset
    input wire clock_i,
    input wire reset_i,
    // User command port
    input wire cmd_valid_i,
    input wire [2:0] cmd_op_i,
    input wire [AW-1:0] cmd_addr_i,
    input wire [7:0] cmd_data_i,
    input wire [5:0] cmd_count_i,
    output reg cmd_ready_o,
    // Buffer data feed, one pair per request
    input wire load_valid_i,
    input wire [AW-1:0] load_addr_i,
    input wire [7:0] load_data_i,
    output reg load_ready_o,
    // Results
    output reg done_o,
    output reg error_o,
    output reg abort_seen_o,
    output reg [7:0] result_o,
    output reg [23:0] dev_id_o,
    // Flash pins
    output reg [AW-1:0] flash_addr_o,
    output reg flash_ce_n_o,
    output reg flash_we_n_o,
    output reg flash_oe_n_o,
    output reg [7:0] flash_dq_o,
    output reg flash_dq_oe_o,
    input wire [7:0] flash_dq_i,
    input wire flash_ready_i,
    output reg flash_reset_n_o
);
    // User operation codes
    localparam OP_ID = 3'h0;
    localparam OP_PROG = 3'h1;
    localparam OP_BUF = 3'h2;
    localparam OP_RESET = 3'h3;
    localparam OP_HWRESET = 3'h4;
    // Sequencer states
    localparam S_IDLE = 4'h0;
    localparam S_UNLK1 = 4'h1;
    localparam S_UNLK2 = 4'h2;
    localparam S_CMD = 4'h3;
    localparam S_IDRD = 4'h4;
    localparam S_PAIR = 4'h5;
    localparam S_COUNT = 4'h6;
    localparam S_LOAD = 4'h7;
    localparam S_COMMIT = 4'h8;
    localparam S_POLL = 4'h9;
    localparam S_RSTCMD = 4'hA;
    localparam S_HWRST = 4'hB;
    localparam S_DONE = 4'hC;
    // Cycle timing derived from clock period
    localparam STROBE_CYC = (`FPS_STROBE_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS;
    localparam READ_CYC = (`FPS_READ_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS;

    // Control registers
    reg [3:0] state_ff;
    reg [2:0] op_ff;
    reg [AW-1:0] addr_ff;
    reg [7:0] data_ff;
    reg [5:0] left_ff;
    reg [1:0] idx_ff;
    reg [1:0] rst_step_ff;
    reg abort_pend_ff;
    reg [7:0] prev_ff;
    reg poll_first_ff;
    reg rdy_s1_ff;
    reg rdy_s2_ff;
    // Bus cycle engine handshake
    reg bc_start_ff;
    reg bc_write_ff;
    reg [AW-1:0] bc_addr_ff;
    reg [7:0] bc_wdata_ff;
    wire bc_done;
    wire [7:0] bc_rdata;
    wire [AW-1:0] pin_addr;
    wire pin_ce_n;
    wire pin_we_n;
    wire pin_oe_n;
    wire [7:0] pin_dq;
    wire pin_dq_oe;
    reg bc_busy_ff;

    // Pin engine: address before falling strobe, data held past rising edge
    fps_bus_cycle #(.AW(AW), .STROBE_CYC(STROBE_CYC), .READ_CYC(READ_CYC)) u_cycle (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .start_i(bc_start_ff),
        .write_i(bc_write_ff),
        .addr_i(bc_addr_ff),
        .wdata_i(bc_wdata_ff),
        .done_o(bc_done),
        .rdata_o(bc_rdata),
        .flash_addr_o(pin_addr),
        .flash_ce_n_o(pin_ce_n),
        .flash_we_n_o(pin_we_n),
        .flash_oe_n_o(pin_oe_n),
        .flash_dq_o(pin_dq),
        .flash_dq_oe_o(pin_dq_oe),
        .flash_dq_i(flash_dq_i)
    );

    // Register the pins so every top output leaves a flip-flop
    always @(posedge clock_i) begin
        if (reset_i) begin
            flash_addr_o <= {AW{1'b0}};
            flash_ce_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_dq_o <= 8'h00;
            flash_dq_oe_o <= 1'b0;
        end else begin
            flash_addr_o <= pin_addr;
            flash_ce_n_o <= pin_ce_n;
            flash_we_n_o <= pin_we_n;
            flash_oe_n_o <= pin_oe_n;
            flash_dq_o <= pin_dq;
            flash_dq_oe_o <= pin_dq_oe;
        end
    end

    // Ready input synchroniser
    always @(posedge clock_i) begin
        rdy_s1_ff <= flash_ready_i;
        rdy_s2_ff <= rdy_s1_ff;
    end

    // Identifier read address for each step
    function [7:0] id_low;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: id_low = `FPS_ID_DEV1_ADDR;
                2'h1: id_low = `FPS_ID_DEV2_ADDR;
                2'h2: id_low = `FPS_ID_DEV3_ADDR;
                default: id_low = `FPS_ID_MANUF_ADDR;
            endcase
        end
    endfunction

    // Main command sequencer
    always @(posedge clock_i) begin
        if (reset_i) begin
            state_ff <= S_IDLE;
            op_ff <= OP_ID;
            addr_ff <= {AW{1'b0}};
            data_ff <= 8'h00;
            left_ff <= 6'h00;
            idx_ff <= 2'h0;
            rst_step_ff <= 2'h0;
            abort_pend_ff <= 1'b0;
            prev_ff <= 8'h00;
            poll_first_ff <= 1'b0;
            bc_start_ff <= 1'b0;
            bc_write_ff <= 1'b0;
            bc_addr_ff <= {AW{1'b0}};
            bc_wdata_ff <= 8'h00;
            bc_busy_ff <= 1'b0;
            cmd_ready_o <= 1'b0;
            load_ready_o <= 1'b0;
            done_o <= 1'b0;
            error_o <= 1'b0;
            abort_seen_o <= 1'b0;
            result_o <= 8'h00;
            dev_id_o <= 24'h000000;
            flash_reset_n_o <= 1'b1;
        end else begin
            bc_start_ff <= 1'b0;
            done_o <= 1'b0;
            load_ready_o <= 1'b0;
            if (bc_done) begin
                bc_busy_ff <= 1'b0;
            end
            case (state_ff)
                S_IDLE: begin
                    cmd_ready_o <= 1'b1;
                    if (cmd_valid_i && cmd_ready_o) begin
                        // Taken only while ready shows, never on a stale request
                        cmd_ready_o <= 1'b0;
                        op_ff <= cmd_op_i;
                        addr_ff <= cmd_addr_i;
                        data_ff <= cmd_data_i;
                        left_ff <= cmd_count_i;
                        idx_ff <= 2'h0;
                        error_o <= 1'b0;
                        if (cmd_op_i == OP_HWRESET) begin
                            // Pin reset aborts a running program
                            flash_reset_n_o <= 1'b0;
                            left_ff <= 6'h00;
                            state_ff <= S_HWRST;
                        end else if (cmd_op_i == OP_RESET) begin
                            // Leaves identifier mode or clears abort
                            rst_step_ff <= abort_pend_ff ? 2'h0 : 2'h2;
                            state_ff <= S_RSTCMD;
                        end else if (abort_pend_ff) begin
                            // Refuse new work until abort reset or pin reset sent
                            error_o <= 1'b1;
                            done_o <= 1'b1;
                        end else if (cmd_op_i == OP_BUF && cmd_count_i >= BUF_BYTES) begin
                            // Count beyond buffer would abort; not issued
                            error_o <= 1'b1;
                            done_o <= 1'b1;
                        end else begin
                            state_ff <= S_UNLK1;
                        end
                    end
                end
                S_UNLK1: begin
                    if (!bc_busy_ff && !bc_start_ff) begin
                        bc_start_ff <= 1'b1;
                        bc_busy_ff <= 1'b1;
                        bc_write_ff <= 1'b1;
                        bc_addr_ff <= `FPS_UNLOCK_ADDR1;
                        bc_wdata_ff <= `FPS_UNLOCK_DATA1;
                        state_ff <= S_UNLK2;
                    end
                end
                S_UNLK2: begin
                    if (bc_done) begin
                        bc_start_ff <= 1'b1;
                        bc_busy_ff <= 1'b1;
                        bc_addr_ff <= `FPS_UNLOCK_ADDR2;
                        bc_wdata_ff <= `FPS_UNLOCK_DATA2;
                        state_ff <= (op_ff == OP_RESET) ? S_RSTCMD : S_CMD;
                    end
                end
                S_CMD: begin
                    if (bc_done) begin
                        bc_start_ff <= 1'b1;
                        bc_busy_ff <= 1'b1;
                        case (op_ff)
                            OP_PROG: begin
                                bc_addr_ff <= `FPS_UNLOCK_ADDR1;
                                bc_wdata_ff <= `FPS_CMD_PROGRAM;
                                state_ff <= S_PAIR;
                            end
                            OP_BUF: begin
                                // Load command at target sector
                                bc_addr_ff <= addr_ff;
                                bc_wdata_ff <= `FPS_CMD_BUF_LOAD;
                                state_ff <= S_COUNT;
                            end
                            default: begin
                                bc_addr_ff <= `FPS_UNLOCK_ADDR1;
                                bc_wdata_ff <= `FPS_CMD_ID_READ;
                                state_ff <= S_IDRD;
                            end
                        endcase
                    end
                end
                S_PAIR: begin
                    if (bc_done) begin
                        // Fourth cycle starts the device's own routine
                        bc_start_ff <= 1'b1;
                        bc_busy_ff <= 1'b1;
                        bc_addr_ff <= addr_ff;
                        bc_wdata_ff <= data_ff;
                        poll_first_ff <= 1'b1;
                        state_ff <= S_POLL;
                    end
                end
                S_COUNT: begin
                    if (bc_done) begin
                        bc_start_ff <= 1'b1;
                        bc_busy_ff <= 1'b1;
                        bc_addr_ff <= addr_ff;
                        bc_wdata_ff <= {2'b00, left_ff};
                        left_ff <= left_ff + 6'h01;
                        state_ff <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    if (bc_done || (!bc_busy_ff && !bc_start_ff)) begin
                        if (left_ff == 6'h00) begin
                            // Commit at sector after all loads
                            bc_start_ff <= 1'b1;
                            bc_busy_ff <= 1'b1;
                            bc_addr_ff <= addr_ff;
                            bc_wdata_ff <= `FPS_CMD_BUF_COMMIT;
                            poll_first_ff <= 1'b1;
                            state_ff <= S_COMMIT;
                        end else if (load_valid_i) begin
                            // Pair outside the page is passed on; device aborts
                            load_ready_o <= 1'b1;
                            bc_start_ff <= 1'b1;
                            bc_busy_ff <= 1'b1;
                            bc_addr_ff <= load_addr_i;
                            bc_wdata_ff <= load_data_i;
                            data_ff <= load_data_i;
                            left_ff <= left_ff - 6'h01;
                            if (left_ff == 6'h01) begin
                                // Last pair sets the commit and poll address
                                addr_ff <= load_addr_i;
                            end
                        end
                    end
                end
                S_COMMIT: begin
                    if (bc_done) begin
                        addr_ff <= bc_addr_ff;
                        state_ff <= S_POLL;
                    end
                end
                S_POLL: begin
                    // Read status at the programmed or last loaded address until done
                    if (bc_done && !bc_write_ff) begin
                        prev_ff <= bc_rdata;
                        if (!poll_first_ff
                            && bc_rdata[`FPS_TOGGLE_BIT] == prev_ff[`FPS_TOGGLE_BIT]
                            && rdy_s2_ff) begin
                            // Toggle stopped and ready high: finished
                            error_o <= (bc_rdata != data_ff);
                            result_o <= bc_rdata;
                            state_ff <= S_DONE;
                        end else if (bc_rdata[`FPS_ABORT_BIT]
                            && !bc_rdata[`FPS_TIMEOUT_BIT]
                            && op_ff == OP_BUF) begin
                            abort_pend_ff <= 1'b1;
                            abort_seen_o <= 1'b1;
                            error_o <= 1'b1;
                            result_o <= bc_rdata;
                            state_ff <= S_DONE;
                        end else if (bc_rdata[`FPS_TIMEOUT_BIT] && !poll_first_ff
                            && !rdy_s2_ff) begin
                            // Bit 5 means timeout only while busy, not in array data
                            error_o <= 1'b1;
                            result_o <= bc_rdata;
                            state_ff <= S_DONE;
                        end
                        poll_first_ff <= 1'b0;
                    end
                    if ((bc_done || !bc_busy_ff) && !bc_start_ff
                        && state_ff == S_POLL) begin
                        // No commands sent while device runs its routine
                        bc_start_ff <= 1'b1;
                        bc_busy_ff <= 1'b1;
                        bc_write_ff <= 1'b0;
                        bc_addr_ff <= addr_ff;
                    end
                end
                S_IDRD: begin
                    // Identifier mode: read the three device code bytes, then the protection byte
                    if (bc_done && !bc_write_ff) begin
                        if (idx_ff == 2'h3) begin
                            result_o <= bc_rdata;
                            state_ff <= S_DONE;
                        end else begin
                            dev_id_o <= {dev_id_o[15:0], bc_rdata};
                            idx_ff <= idx_ff + 2'h1;
                        end
                    end
                    if ((bc_done || !bc_busy_ff) && !bc_start_ff && state_ff == S_IDRD
                        && !(bc_done && !bc_write_ff && idx_ff == 2'h3)) begin
                        bc_start_ff <= 1'b1;
                        bc_busy_ff <= 1'b1;
                        bc_write_ff <= 1'b0;
                        // Last read is protection at sector plus 02
                        bc_addr_ff <= {addr_ff[AW-1:8],
                            (bc_done && !bc_write_ff && idx_ff == 2'h2) ?
                            `FPS_ID_PROT_ADDR :
                            id_low(idx_ff + ((bc_done && !bc_write_ff) ? 2'h1 : 2'h0))};
                    end
                end
                S_RSTCMD: begin
                    // Full three-cycle abort reset, or single reset
                    if (rst_step_ff == 2'h0) begin
                        rst_step_ff <= 2'h1;
                        state_ff <= S_UNLK1;
                    end else if ((rst_step_ff == 2'h2 && !bc_busy_ff && !bc_start_ff)
                        || (rst_step_ff == 2'h1 && bc_done)) begin
                        bc_start_ff <= 1'b1;
                        bc_busy_ff <= 1'b1;
                        bc_write_ff <= 1'b1;
                        bc_addr_ff <= `FPS_UNLOCK_ADDR1;
                        bc_wdata_ff <= `FPS_CMD_RESET;
                        rst_step_ff <= 2'h3;
                    end else if (rst_step_ff == 2'h3 && bc_done) begin
                        abort_pend_ff <= 1'b0;
                        abort_seen_o <= 1'b0;
                        state_ff <= S_DONE;
                    end
                end
                S_HWRST: begin
                    // Hold reset pin low while counting, then release
                    left_ff <= left_ff + 6'h01;
                    if (left_ff == 6'h3F) begin
                        flash_reset_n_o <= 1'b1;
                        abort_pend_ff <= 1'b0;
                        abort_seen_o <= 1'b0;
                        state_ff <= S_DONE;
                    end
                end
                S_DONE: begin
                    done_o <= 1'b1;
                    state_ff <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule // fps_sequencer

/* File: sim/fps_sequencer_checker.sv */
// Checker of host pin timing and command handshake of the flash sequencer
`timescale 1ns/100ps
module fps_sequencer_checker #(parameter AW = 22) (
    // Clock, reset and command port
    input wire clock_i, reset_i, cmd_valid_i, cmd_ready_o, done_o, error_o,
    input wire [2:0] cmd_op_i,
    input wire [5:0] cmd_count_i,
    // Flash pins
    input wire [AW-1:0] flash_addr_o,
    input wire flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_dq_oe_o, flash_reset_n_o,
    input wire [7:0] flash_dq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    strobe_overlap_a: assert property (flash_we_n_o || flash_oe_n_o)
        else $error("write and read strobes overlap");
    drive_on_read_a: assert property (flash_dq_oe_o |-> flash_oe_n_o)
        else $error("data driven during read");
    write_selected_a: assert property (!flash_we_n_o |-> !flash_ce_n_o)
        else $error("write strobe without chip select");
    write_hold_a: assert property (!flash_we_n_o && $past(!flash_we_n_o) |->
        $stable(flash_addr_o) && $stable(flash_dq_o)) else $error("write pins moved");
    write_width_a: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o [*2])
        else $error("write strobe too short");
    accept_drop_a: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
        else $error("ready held after accept");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    count_refused_a: assert property (cmd_valid_i && cmd_ready_o && cmd_op_i == 3'h2 &&
        cmd_count_i > 6'h1F |-> ##[1:4] done_o && error_o) else $error("count not refused");
    hw_reset_width_a: assert property ($fell(flash_reset_n_o) |-> !flash_reset_n_o [*8])
        else $error("reset pulse too short");
endmodule // fps_sequencer_checker
bind fps_sequencer fps_sequencer_checker #(.AW(AW)) fps_sequencer_checker_inst (.*);

/* File: sim/fps_flash_model.sv */
// Behavioural flash device answering the sequencer on its pins
`timescale 1ns/100ps
module fps_flash_model #(
    parameter LAT = 3000,
    parameter MANUF = 8'h5A, // Arbitrary maker code
    parameter DEV_ID = 24'h112233 // Arbitrary device code
) (
    // Flash pins
    input wire [21:0] a_i,
    input wire ce_n_i, we_n_i, oe_n_i, rst_n_i,
    input wire [7:0] d_i,
    output wire [7:0] d_o,
    output reg rdy_o = 1
);
    reg [7:0] mem [0:63];
    reg [7:0] bf [0:31];
    reg [31:0] bv;
    reg [3:0] st = 0; // 0 array, 1 id, 2 program, 3 count, 4 load, 5 commit, 6 abort
    reg [1:0] u = 0; // Unlock progress
    reg [5:0] n;
    reg [21:0] pa, la;
    reg [7:0] ld = 0, last = 0;
    reg tog = 0;
    integer i;
    wire [7:0] idv = a_i[7:0] == 0 ? MANUF : a_i[7:0] == 1 ? DEV_ID[23:16] :
        a_i[7:0] == 14 ? DEV_ID[15:8] : a_i[7:0] == 15 ? DEV_ID[7:0] : {7'h00, a_i[12]};
    wire [7:0] rd = !rdy_o ? {~ld[7], tog, 6'h00} : st == 6 ? {~ld[7], tog, 6'h02} :
        st == 1 ? idv : mem[a_i[5:0]];
    // Released bus shows the inverse of its last value
    assign d_o = (!oe_n_i && !ce_n_i) ? rd : ~last;
    initial for (i = 0; i < 64; i = i + 1) mem[i] = 8'hFF;
    always @(negedge oe_n_i) tog = ~tog;
    always @(posedge oe_n_i) last = rd;
    // Self-timed program routine
    always @(negedge rdy_o) #LAT rdy_o = 1;
    always @(negedge rst_n_i) begin st = 0; u = 0; rdy_o = 1; end
    // Command decoding on the closing write edge
    always @(posedge we_n_i) if (!ce_n_i && rdy_o && rst_n_i) begin
        if (d_i == 8'hF0 && st != 2 && st != 4 && (st != 6 || u == 2)) begin
            st = 0;
            u = 0;
        end else case (st)
            2: begin mem[a_i[5:0]] = mem[a_i[5:0]] & d_i; ld = d_i; st = 0; rdy_o = 0; end
            3: begin n = d_i[5:0]; bv = 0; st = (d_i > 31 || a_i[21:12] != pa[21:12]) ? 6 : 4; end
            4: if (a_i[21:12] != pa[21:12] || (bv != 0 && a_i[21:4] != la[21:4])) st = 6;
                else begin bf[a_i[4:0]] = d_i; bv[a_i[4:0]] = 1; la = a_i; ld = d_i;
                    st = n != 0 ? 4 : 5; n = n - 1; end
            5: if (d_i == 8'h29 && a_i[21:12] == pa[21:12]) begin
                    for (i = 0; i < 32; i = i + 1) if (bv[i]) mem[{la[5], i[4:0]}] = mem[{la[5], i[4:0]}] & bf[i];
                    st = 0; rdy_o = 0; end else st = 6;
            default: if (u == 2 && st != 6) begin
                    st = d_i == 8'h90 ? 1 : d_i == 8'hA0 ? 2 : d_i == 8'h25 ? 3 : st; pa = a_i; u = 0;
                end else u = d_i == 8'hAA ? 1 : (u == 1 && d_i == 8'h55) ? 2 : 0;
        endcase
    end
endmodule // fps_flash_model

/* File: sim/fps_sequencer_tb.sv */
// Self-checking bench: sequencer against the behavioural flash device
`timescale 1ns/100ps
module fps_sequencer_tb;
    localparam ID = 24'hA1B2C3; // Arbitrary device code
    reg clock_i = 0, reset_i = 1, cmd_valid_i = 0, load_valid_i = 0;
    reg [2:0] cmd_op_i = 0;
    reg [21:0] cmd_addr_i = 0, load_addr_i = 0;
    reg [7:0] cmd_data_i = 0, load_data_i = 0;
    reg [5:0] cmd_count_i = 0;
    wire cmd_ready_o, load_ready_o, done_o, error_o, abort_seen_o, flash_ready_i, flash_reset_n_o;
    wire flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_dq_oe_o;
    wire [7:0] result_o, flash_dq_o, dq_m;
    wire [7:0] flash_dq_i = flash_dq_oe_o ? flash_dq_o : dq_m;
    wire [23:0] dev_id_o;
    wire [21:0] flash_addr_o;
    reg [21:0] la [0:3];
    reg [7:0] ld [0:3];
    integer li = 0, np = 0, n_errors = 0, checked = 0, i;
    fps_sequencer fps_sequencer_inst (.*);
    fps_flash_model #(.DEV_ID(ID)) fps_flash_model_inst (.a_i(flash_addr_o), .ce_n_i(flash_ce_n_o),
        .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o), .rst_n_i(flash_reset_n_o), .d_i(flash_dq_o),
        .d_o(dq_m), .rdy_o(flash_ready_i));
    initial forever #10 clock_i = ~clock_i;
    // Buffer pair feeder, advances on each taken pair
    always @(negedge clock_i) begin
        if (load_ready_o === 1'b1) li = li + 1;
        load_valid_i = li < np;
        load_addr_i = la[li[1:0]];
        load_data_i = ld[li[1:0]];
    end
    task final_report;
        begin
            if (n_errors == 0 && checked > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [23:0] s, input [23:0] e);
        begin
            checked = checked + 1;
            if (s !== e) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: %h expected %h", $time, s, e);
            end
        end
    endtask
    // One command through the user port, bounded waits
    task op(input [2:0] o, input [21:0] a, input [7:0] d, input [5:0] c);
        integer k;
        begin
            @(negedge clock_i);
            {cmd_op_i, cmd_addr_i, cmd_data_i, cmd_count_i, cmd_valid_i} = {o, a, d, c, 1'b1};
            k = 0;
            while (cmd_ready_o !== 1'b1 && k < 100) begin @(negedge clock_i); k = k + 1; end
            @(negedge clock_i);
            cmd_valid_i = 0;
            while (done_o !== 1'b1 && k < 5000) begin @(negedge clock_i); k = k + 1; end
            if (k >= 5000) begin n_errors = n_errors + 1; final_report; end
        end
    endtask
    initial begin
        repeat (12) @(negedge clock_i);
        reset_i = 0;
        op(0, 22'h001000, 0, 0); chk(result_o, 1); chk(dev_id_o, ID);
        op(3, 0, 0, 0); op(0, 0, 0, 0); chk(result_o, 0);
        op(3, 0, 0, 0); op(1, 22'h10, 8'h5A, 0); chk(error_o, 0);
        op(1, 22'h10, 8'hFF, 0); chk(error_o, 1);
        la[0] = 22'h20; la[1] = 22'h21; la[2] = 22'h20; ld[0] = 8'h11; ld[1] = 8'h22; ld[2] = 8'h33;
        li = 0; np = 3;
        op(2, 0, 0, 2); chk(error_o, 0); chk(abort_seen_o, 0);
        op(1, 22'h20, 8'h33, 0); chk(error_o, 0);
        op(2, 0, 0, 32); chk(error_o, 1);
        for (i = 0; i < 2; i = i + 1) begin
            la[0] = i ? 22'h20 : 22'h1020; la[1] = 22'h30; li = 0; np = i + 1;
            op(2, 0, 0, i); chk(abort_seen_o, 1);
            op(1, 22'h11, 0, 0); chk(error_o, 1);
            op(3, 0, 0, 0); chk(abort_seen_o, 0);
        end
        op(4, 0, 0, 0); op(1, 22'h12, 8'h0F, 0); chk(error_o, 0);
        final_report;
    end
endmodule // fps_sequencer_tb
